// [hdl/query_table_pkg.sv]
// Purpose: constants for the query database responder
// Assumes: sixteen-bit word-wide flash bus, word addressing
// Notes: database bytes sit in the low lane, upper lane always zero
`default_nettype none
package query_table_pkg;
	// ***********************************
	// bus widths
	// ***********************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam logic [7:0] UPPER_LANE = 8'h00;
	localparam logic [7:0] BYTE_NONE = 8'h00;
	// ***********************************
	// command codes
	// ***********************************
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	// ***********************************
	// database offsets (word addresses)
	// ***********************************
	localparam logic [7:0] OFS_TABLE_START = 8'h10;
	localparam logic [7:0] OFS_SIG_Q = 8'h10;
	localparam logic [7:0] OFS_SIG_R = 8'h11;
	localparam logic [7:0] OFS_SIG_Y = 8'h12;
	localparam logic [7:0] OFS_CMDSET_LO = 8'h13;
	localparam logic [7:0] OFS_CMDSET_HI = 8'h14;
	localparam logic [7:0] OFS_EXT_PTR_LO = 8'h15;
	localparam logic [7:0] OFS_EXT_PTR_HI = 8'h16;
	localparam logic [7:0] OFS_ALT_CMDSET_LO = 8'h17;
	localparam logic [7:0] OFS_ALT_CMDSET_HI = 8'h18;
	localparam logic [7:0] OFS_ALT_PTR_LO = 8'h19;
	localparam logic [7:0] OFS_ALT_PTR_HI = 8'h1a;
	localparam logic [7:0] OFS_SYS_IF_START = 8'h1b;
	localparam logic [7:0] OFS_CORE_MIN = 8'h1b;
	localparam logic [7:0] OFS_CORE_MAX = 8'h1c;
	localparam logic [7:0] OFS_PROG_MIN = 8'h1d;
	localparam logic [7:0] OFS_PROG_MAX = 8'h1e;
	localparam logic [7:0] OFS_WORD_TYP = 8'h1f;
	localparam logic [7:0] OFS_BUF_TYP = 8'h20;
	localparam logic [7:0] OFS_BLK_TYP = 8'h21;
	localparam logic [7:0] OFS_CHIP_TYP = 8'h22;
	localparam logic [7:0] OFS_WORD_MAX = 8'h23;
	localparam logic [7:0] OFS_BUF_MAX = 8'h24;
	localparam logic [7:0] OFS_BLK_MAX = 8'h25;
	localparam logic [7:0] OFS_CHIP_MAX = 8'h26;
	localparam logic [7:0] OFS_GEOMETRY_START = 8'h27;
	// ***********************************
	// database contents
	// ***********************************
	localparam logic [7:0] VAL_SIG_Q = 8'h51;
	localparam logic [7:0] VAL_SIG_R = 8'h52;
	localparam logic [7:0] VAL_SIG_Y = 8'h59;
	localparam logic [15:0] VAL_EXT_PTR = 16'h010a;
	localparam logic [15:0] VAL_ALT_CMDSET = 16'h0000;
	localparam logic [15:0] VAL_ALT_PTR = 16'h0000;
	localparam logic [7:0] VAL_CORE_MIN = 8'h17;
	localparam logic [7:0] VAL_CORE_MAX = 8'h20;
	localparam logic [7:0] VAL_PROG_MIN = 8'h85;
	localparam logic [7:0] VAL_PROG_MAX = 8'h95;
	localparam logic [7:0] VAL_WORD_TYP = 8'h08;
	localparam logic [7:0] VAL_BUF_TYP = 8'h09;
	localparam logic [7:0] VAL_BLK_TYP = 8'h0a;
	localparam logic [7:0] VAL_CHIP_TYP = 8'h00;
	localparam logic [7:0] VAL_WORD_MAX = 8'h01;
	localparam logic [7:0] VAL_BUF_MAX = 8'h01;
	localparam logic [7:0] VAL_BLK_MAX = 8'h02;
	localparam logic [7:0] VAL_CHIP_MAX = 8'h00;
	// ***********************************
	// reset values
	// ***********************************
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [7:0] ADDR_RESET = 8'h00;
endpackage
`default_nettype wire

// [hdl/query_table_responder.sv]
// Purpose: query database responder on the word-wide flash read path
// Assumes: pins asynchronous to CLK; array data arrives on CLK
// Notes: query and array reads share one read timing
//
// Summary of operation
// - after query command, reads return database until another mode command
// - query bytes appear only on data bits seven to zero
// - upper data byte reads zero while in query mode
// - database starts at word address 10h; host uses word addressing
// - multi-byte fields: least significant byte at lowest address
// - words 10h, 11h, 12h return 51, 52, 59
// - primary command-set code returned little-endian from 13h
// - 15h and 16h return extended table pointer 0A then 01
// - 17h and 18h return zero: no alternate command set
// - 19h and 1Ah return zero: no secondary extended table
// - core supply minimum 17 at 1Bh, maximum 20 at 1Ch
// - programming supply minimum 85 at 1Dh, maximum 95 at 1Eh
// - typical exponents: 08 at 1Fh, 09 at 20h, 0A at 21h
// - chip erase unsupported: 22h and 26h return zero
// - maximum multiplier exponents at 23h to 25h; block erase is 02
// - interface info from 1Bh, geometry from 27h, below 10h reserved
`timescale 1ns/1ps
`default_nettype none
module query_table_responder
	import query_table_pkg::*;
#(
	// arbitrary neutral value
	parameter logic [15:0] PRIMARY_ALGORITHM = 16'h00a5
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE_N,
	input wire logic OE_N,
	input wire logic WE_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [DATA_W-1:0] DQ_IN,
	input wire logic [DATA_W-1:0] ARRAY_DATA,
	output logic [DATA_W-1:0] DQ_OUT,
	output logic DQ_OE,
	output logic QUERY_MODE
);
	// ***********************************
	// pin synchronisers
	// ***********************************
	logic ce_n_m_q, oe_n_m_q, we_n_m_q;
	logic ce_n_s_q, oe_n_s_q, we_n_s_q, we_n_prev_q;
	logic [ADDR_W-1:0] addr_m_q, addr_s_q;
	logic [DATA_W-1:0] dq_m_q, dq_s_q;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ce_n_m_q <= PIN_IDLE;
			oe_n_m_q <= PIN_IDLE;
			we_n_m_q <= PIN_IDLE;
			ce_n_s_q <= PIN_IDLE;
			oe_n_s_q <= PIN_IDLE;
			we_n_s_q <= PIN_IDLE;
			we_n_prev_q <= PIN_IDLE;
			addr_m_q <= ADDR_RESET;
			addr_s_q <= ADDR_RESET;
			dq_m_q <= DATA_RESET;
			dq_s_q <= DATA_RESET;
		end else begin
			ce_n_m_q <= CE_N;
			oe_n_m_q <= OE_N;
			we_n_m_q <= WE_N;
			ce_n_s_q <= ce_n_m_q;
			oe_n_s_q <= oe_n_m_q;
			we_n_s_q <= we_n_m_q;
			we_n_prev_q <= we_n_s_q;
			addr_m_q <= ADDR;
			addr_s_q <= addr_m_q;
			dq_m_q <= DQ_IN;
			dq_s_q <= dq_m_q;
		end
	end

	// ***********************************
	// bus cycle decode
	// ***********************************
	logic wr_pulse, rd_active;
	logic [7:0] cmd;

	// command taken at the trailing edge of write enable
	assign wr_pulse = we_n_s_q && !we_n_prev_q && !ce_n_s_q;
	assign rd_active = !ce_n_s_q && !oe_n_s_q && we_n_s_q;
	assign cmd = dq_s_q[7:0];

	// ***********************************
	// mode tracking
	// ***********************************
	logic query_q;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			query_q <= 1'b0;
		end else if (wr_pulse) begin
			// any other command, read-array included, leaves query mode
			query_q <= (cmd == CMD_QUERY);
		end
	end

	// ***********************************
	// database lookup
	// ***********************************
	function automatic logic [7:0] query_byte(input logic [7:0] ofs);
		logic [7:0] b;
		b = BYTE_NONE;
		case (ofs)
			OFS_SIG_Q: b = VAL_SIG_Q;
			OFS_SIG_R: b = VAL_SIG_R;
			OFS_SIG_Y: b = VAL_SIG_Y;
			OFS_CMDSET_LO: b = PRIMARY_ALGORITHM[7:0];
			OFS_CMDSET_HI: b = PRIMARY_ALGORITHM[15:8];
			OFS_EXT_PTR_LO: b = VAL_EXT_PTR[7:0];
			OFS_EXT_PTR_HI: b = VAL_EXT_PTR[15:8];
			OFS_ALT_CMDSET_LO: b = VAL_ALT_CMDSET[7:0];
			OFS_ALT_CMDSET_HI: b = VAL_ALT_CMDSET[15:8];
			OFS_ALT_PTR_LO: b = VAL_ALT_PTR[7:0];
			OFS_ALT_PTR_HI: b = VAL_ALT_PTR[15:8];
			OFS_CORE_MIN: b = VAL_CORE_MIN;
			OFS_CORE_MAX: b = VAL_CORE_MAX;
			OFS_PROG_MIN: b = VAL_PROG_MIN;
			OFS_PROG_MAX: b = VAL_PROG_MAX;
			OFS_WORD_TYP: b = VAL_WORD_TYP;
			OFS_BUF_TYP: b = VAL_BUF_TYP;
			OFS_BLK_TYP: b = VAL_BLK_TYP;
			OFS_CHIP_TYP: b = VAL_CHIP_TYP;
			OFS_WORD_MAX: b = VAL_WORD_MAX;
			OFS_BUF_MAX: b = VAL_BUF_MAX;
			OFS_BLK_MAX: b = VAL_BLK_MAX;
			OFS_CHIP_MAX: b = VAL_CHIP_MAX;
			// reserved below 10h and geometry region read as zero
			default: b = BYTE_NONE;
		endcase
		return b;
	endfunction

	// ***********************************
	// read data path
	// ***********************************
	logic [DATA_W-1:0] dq_out_q;
	logic dq_oe_q;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dq_out_q <= DATA_RESET;
		end else if (rd_active) begin
			if (query_q) begin
				dq_out_q <= {UPPER_LANE, query_byte(addr_s_q)};
			end else begin
				dq_out_q <= ARRAY_DATA;
			end
		end
	end

	// same enable timing in both modes
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dq_oe_q <= 1'b0;
		end else begin
			dq_oe_q <= rd_active;
		end
	end

	assign DQ_OUT = dq_out_q;
	assign DQ_OE = dq_oe_q;
	assign QUERY_MODE = query_q;

	// ***********************************
	// checks
	// ***********************************
	logic qrd_q;
	logic [7:0] qaddr_q;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			qrd_q <= 1'b0;
			qaddr_q <= ADDR_RESET;
		end else begin
			qrd_q <= rd_active && query_q;
			qaddr_q <= addr_s_q;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	chk_query_entry: assert property (wr_pulse && cmd == CMD_QUERY |=> query_q [*2] or (query_q ##1 wr_pulse))
		else $error("query command did not enter query mode");
	chk_query_exit: assert property (wr_pulse && cmd == CMD_READ_ARRAY |=> !query_q)
		else $error("read-array command did not leave query mode");
	chk_upper_zero: assert property (qrd_q |-> DQ_OE && DQ_OUT[15:8] == UPPER_LANE)
		else $error("upper lane not zero in query read");
	chk_signature_bytes: assert property (qrd_q && qaddr_q == OFS_SIG_R |-> DQ_OUT[7:0] == VAL_SIG_R)
		else $error("signature byte wrong");
	chk_cmdset_order: assert property (qrd_q && qaddr_q == OFS_CMDSET_HI |-> DQ_OUT[7:0] == PRIMARY_ALGORITHM[15:8])
		else $error("command-set high byte wrong");
	chk_ext_pointer: assert property (qrd_q && qaddr_q == OFS_EXT_PTR_LO |-> DQ_OUT[7:0] == VAL_EXT_PTR[7:0])
		else $error("extended pointer low byte wrong");
	chk_alt_absent: assert property (qrd_q && qaddr_q >= OFS_ALT_CMDSET_LO && qaddr_q <= OFS_ALT_PTR_HI
		|-> DQ_OUT == DATA_RESET)
		else $error("alternate fields not zero");
	chk_supply_bytes: assert property (qrd_q && qaddr_q == OFS_PROG_MAX |-> DQ_OUT[7:0] == VAL_PROG_MAX)
		else $error("programming supply maximum wrong");
	chk_erase_max: assert property (qrd_q && qaddr_q == OFS_BLK_MAX |-> DQ_OUT[7:0] == VAL_BLK_MAX)
		else $error("block erase multiplier wrong");
	chk_reserved_zero: assert property (qrd_q && qaddr_q < OFS_TABLE_START |-> DQ_OUT == DATA_RESET)
		else $error("reserved offset not zero");
	chk_read_timing: assert property (rd_active |=> DQ_OE)
		else $error("output enable late");
	chk_read_release: assert property (!rd_active |=> !DQ_OE)
		else $error("output enable held after read");
	chk_cmdset_low: assert property (qrd_q && qaddr_q == OFS_CMDSET_LO |-> DQ_OUT[7:0] == PRIMARY_ALGORITHM[7:0])
		else $error("command-set low byte wrong");
	chk_core_supply: assert property (qrd_q && qaddr_q == OFS_CORE_MIN |-> DQ_OUT[7:0] == VAL_CORE_MIN)
		else $error("core supply minimum wrong");
	chk_typ_exponent: assert property (qrd_q && qaddr_q == OFS_BLK_TYP |-> DQ_OUT[7:0] == VAL_BLK_TYP)
		else $error("block erase typical exponent wrong");
	chk_chip_erase: assert property (qrd_q && (qaddr_q == OFS_CHIP_TYP || qaddr_q == OFS_CHIP_MAX)
		|-> DQ_OUT == DATA_RESET)
		else $error("chip erase bytes not zero");
	chk_geometry_zero: assert property (qrd_q && qaddr_q >= OFS_GEOMETRY_START |-> DQ_OUT == DATA_RESET)
		else $error("geometry region not zero");
	chk_array_path: assert property (rd_active && !query_q |=> DQ_OUT == $past(ARRAY_DATA))
		else $error("array data not returned");

	cov_query_read: cover property (wr_pulse && cmd == CMD_QUERY ##[1:20] qrd_q && qaddr_q == OFS_SIG_Q);
	cov_query_exit: cover property (query_q ##1 wr_pulse && cmd == CMD_READ_ARRAY ##[1:20] DQ_OE && !QUERY_MODE);
	cov_blk_typ: cover property (qrd_q && qaddr_q == OFS_BLK_TYP);
	cov_array_read: cover property (rd_active && !query_q ##1 DQ_OE);
	cov_reserved_read: cover property (qrd_q && qaddr_q < OFS_TABLE_START);
endmodule
`default_nettype wire

// [sim/flash_host.sv]
// Purpose: host controller model driving the flash pins
// Assumes: pins change just after a rising edge, held until answered
// Notes: released data and address pins show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module flash_host
	import query_table_pkg::*;
(
	input wire logic clk,
	input wire logic dq_oe,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dq_in
);
	initial begin
		ce_n = PIN_IDLE;
		oe_n = PIN_IDLE;
		we_n = PIN_IDLE;
		addr = ADDR_RESET;
		dq_in = DATA_RESET;
	end
	task automatic wr_cmd(input logic [DATA_W-1:0] d);
		@(posedge clk);
		ce_n <= 1'b0;
		we_n <= 1'b0;
		dq_in <= d;
		repeat (3) @(posedge clk);
		we_n <= 1'b1;
		repeat (2) @(posedge clk);
		ce_n <= 1'b1;
		dq_in <= ~d;
		repeat (3) @(posedge clk);
	endtask
	task automatic rd_word(input logic [ADDR_W-1:0] a, output logic ok);
		int n;
		@(posedge clk);
		ce_n <= 1'b0;
		oe_n <= 1'b0;
		addr <= a;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dq_oe !== 1'b1 && n < 10);
		ok = (dq_oe === 1'b1);
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dq_oe !== 1'b0 && n < 10);
		addr <= ~a;
	endtask
endmodule
`default_nettype wire

// [sim/query_table_responder_tb.sv]
// Purpose: self-checking bench for the query database responder
// Assumes: host model drives the pins, bench drives array data
// Notes: reads are scored from a queue of expected words
`timescale 1ns/1ps
`default_nettype none
module query_table_responder_tb
	import query_table_pkg::*;
;
	// ***********************************
	// signals and instances
	// ***********************************
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic CE_N, OE_N, WE_N, DQ_OE, QUERY_MODE, ok;
	logic prev_oe = 1'b0;
	logic [ADDR_W-1:0] ADDR;
	logic [DATA_W-1:0] DQ_IN, DQ_OUT;
	logic [DATA_W-1:0] ARRAY_DATA = 16'h0000;
	logic [DATA_W-1:0] exp_q[$];
	logic [7:0] tab[23] = '{8'h51, 8'h52, 8'h59, 8'h96, 8'h3c, 8'h0a, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h17, 8'h20, 8'h85, 8'h95, 8'h08, 8'h09, 8'h0a, 8'h00, 8'h01, 8'h01, 8'h02, 8'h00};
	logic [7:0] codes[2] = '{8'h70, CMD_READ_ARRAY};
	int error_cnt = 0;
	int tests_run = 0;
	always #12.5 CLK = ~CLK;
	query_table_responder #(.PRIMARY_ALGORITHM(16'h3c96)) i_query_table_responder(.CLK(CLK), .NRST(NRST),
		.CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .ADDR(ADDR), .DQ_IN(DQ_IN), .ARRAY_DATA(ARRAY_DATA),
		.DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .QUERY_MODE(QUERY_MODE));
	flash_host i_flash_host(.clk(CLK), .dq_oe(DQ_OE), .ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .addr(ADDR),
		.dq_in(DQ_IN));
	// ***********************************
	// checking
	// ***********************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge CLK) begin
		prev_oe <= DQ_OE;
		if (DQ_OE === 1'b1 && prev_oe === 1'b0) begin
			if (exp_q.size() > 0) begin
				chk(DQ_OUT, exp_q.pop_front());
			end else begin
				chk(16'hdead, 16'hbeef);
			end
		end
	end
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		i_flash_host.rd_word(a, ok);
		chk({15'h0000, ok}, 16'h0001);
	endtask
	function automatic logic [15:0] qexp(input logic [7:0] a);
		return (a >= 8'h10 && a <= 8'h26) ? {8'h00, tab[a - 8'h10]} : 16'h0000;
	endfunction
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(20000 * 25);
		error_cnt++;
		wrap_up();
	end
	// ***********************************
	// tests
	// ***********************************
	initial begin
		logic [7:0] a;
		void'($urandom(32'h81f93383));
		repeat (3) @(posedge CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK);
		chk({14'h0000, DQ_OE, QUERY_MODE}, 16'h0000);
		ARRAY_DATA <= 16'($urandom);
		@(posedge CLK);
		rd(8'h10, ARRAY_DATA);
		$display("test array_read done");
		i_flash_host.wr_cmd({8'($urandom), CMD_QUERY});
		chk({15'h0000, QUERY_MODE}, 16'h0001);
		for (int i = 0; i < 8'h30; i++) rd(8'(i), qexp(8'(i)));
		repeat (4) begin
			a = 8'h30 + 8'($urandom_range(8'hcf));
			rd(a, 16'h0000);
		end
		$display("test query_table done");
		foreach (codes[k]) begin
			i_flash_host.wr_cmd({8'h00, CMD_QUERY});
			rd(8'h10, 16'h0051);
			i_flash_host.wr_cmd({8'($urandom), codes[k]});
			chk({15'h0000, QUERY_MODE}, 16'h0000);
			ARRAY_DATA <= 16'($urandom);
			@(posedge CLK);
			rd(8'h13, ARRAY_DATA);
		end
		$display("test mode_exit done");
		i_flash_host.wr_cmd({8'h00, CMD_QUERY});
		NRST <= 1'b0;
		repeat (2) @(posedge CLK);
		chk(DQ_OUT, DATA_RESET);
		chk({14'h0000, DQ_OE, QUERY_MODE}, 16'h0000);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(8'h11, ARRAY_DATA);
		$display("test mid_reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
